// *** design/ccst_top.v ***
`timescale 1ns/10ps
`default_nettype none
`include "ccst_map.vh"
// Functional notes
// [R1] pin low selects 60Hz, high 50Hz
// [R2] select change only affects current conversion; code latches the choice at the start of the next conversion
// [R3] detect external clock on pin, stop oscillator
// [R4] external clock must be 2560Hz or faster
// [R5] no external clock: return to internal oscillator
// [R6] source change in sleep/output leaves operation intact
// [R7] source change mid-conversion spoils only that result
// [R8] internal serial clock duty may change, data valid
// [R9] 60Hz internal convert lasts 66.6ms
// [R10] 50Hz internal convert lasts 80ms
// [R11] external clock convert lasts 10278 periods
// [R12] internal sck output: 32 cycles, 1.67ms max
// [R13] internal sck, external clock: 256 periods max
// [R14] external sck output: 32 host clocks max
// [R15] status in convert/sleep, result in output
// [R16] combined variant: low pin rejects both
// [R17] host averages two latest combined results
// [R18] combined internal convert lasts 72.8ms
// [R19] combined internal output lasts 1.83ms max
// [R20] internal serial clock is conversion clock/8
// [R21] sleep until sck rises with select low
// [R22] no edge within window means clock absent
// [R23] clock source switch without short pulses
module ccst_top #(
  parameter integer COMBINED  = 0,
  parameter integer CONV60    = `CCST_CONV60_CYC,
  parameter integer CONV50    = `CCST_CONV50_CYC,
  parameter integer CONVCMB   = `CCST_CONVCMB_CYC,
  parameter integer EXT_CONV  = `CCST_EXT_CONV_PERIODS,
  parameter integer WIN_CYC   = `CCST_EXT_WIN_CYC,
  parameter integer TICK_CYC  = `CCST_TICK_CYC,
  parameter integer TICKCMB   = `CCST_TICKCMB_CYC
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        rejection_select_pin,
  input  wire        cs_n,
  input  wire        sck_i,
  input  wire [29:0] result_data,
  output reg         sck_o,
  output reg         sck_oe,
  output reg         serial_out,
  output reg         serial_out_oe,
  output reg         int_osc_en,
  output reg         convert_active
);
  localparam [1:0] ST_CONV  = 2'h0;
  localparam [1:0] ST_SLEEP = 2'h1;
  localparam [1:0] ST_DOUT  = 2'h2;

  wire        ext_sel;
  wire        tick;
  wire        sel_high;
  reg         cs_s1_q;
  reg         cs_s2_q;
  reg         cs_s3_q;
  reg         sck_s1_q;
  reg         sck_s2_q;
  reg         sck_s3_q;
  reg  [1:0]  state_q;
  reg  [31:0] cyc_q;
  reg  [31:0] lim_q;
  reg  [15:0] per_q;
  reg  [29:0] res_q;
  reg  [31:0] shift_q;
  reg  [5:0]  falls_q;
  reg         int_mode_q;
  reg         boot_q;
  reg  [1:0]  ph_q;
  reg         sck_int_q;
  wire        cs_low;
  wire        cs_fall;
  wire        cs_rise;
  wire        gen_on;
  wire        ph_end;
  wire        rise;
  wire        fall;
  wire        conv_done;

  function [31:0] conv_limit;
    input hi;
    begin
      if (hi)
        conv_limit = CONV50; // [R10]
      else if (COMBINED != 0)
        conv_limit = CONVCMB; // [R16] [R18]
      else
        conv_limit = CONV60; // [R9] [R1]
    end
  endfunction

  ccst_clk_sel #(
    .WIN_CYC  (WIN_CYC),
    .TICK_CYC ((COMBINED != 0) ? TICKCMB : TICK_CYC)
  ) u_clk_sel (
    .clk                  (clk),
    .rst                  (rst),
    .rejection_select_pin (rejection_select_pin),
    .ext_sel_q            (ext_sel),
    .conv_tick_q          (tick),
    .sel_high_q           (sel_high)
  );

  assign cs_low  = ~cs_s2_q;
  assign cs_fall = ~cs_s2_q & cs_s3_q;
  assign cs_rise = cs_s2_q & ~cs_s3_q;
  assign gen_on  = int_mode_q & cs_low & (state_q != ST_CONV);
  assign ph_end  = tick & (ph_q == 2'h3);
  // serial clock from conversion clock divided by 8
  assign rise = int_mode_q ? (gen_on & ph_end & ~sck_int_q)
                           : (sck_s2_q & ~sck_s3_q); // [R20]
  assign fall = int_mode_q ? (gen_on & ph_end & sck_int_q)
                           : (~sck_s2_q & sck_s3_q);
  // conversion length in cycles or external periods
  assign conv_done = ext_sel ? (tick && per_q >= EXT_CONV - 1) // [R11] [R7]
                             : (cyc_q >= lim_q - 1);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_s1_q        <= 1'b1;
      cs_s2_q        <= 1'b1;
      cs_s3_q        <= 1'b1;
      sck_s1_q       <= 1'b1;
      sck_s2_q       <= 1'b1;
      sck_s3_q       <= 1'b1;
      state_q        <= ST_CONV;
      cyc_q          <= 32'h0000_0000;
      lim_q          <= (COMBINED != 0) ? CONVCMB : CONV60; // [R9] [R18]
      per_q          <= 16'h0000;
      res_q          <= 30'h0000_0000;
      shift_q        <= 32'hFFFF_FFFF;
      falls_q        <= 6'h00;
      int_mode_q     <= 1'b1;
      boot_q         <= 1'b1;
      ph_q           <= 2'h0;
      sck_int_q      <= 1'b0;
      sck_o          <= 1'b0;
      sck_oe         <= 1'b0;
      serial_out     <= 1'b1;
      serial_out_oe  <= 1'b0;
      int_osc_en     <= 1'b1;
      convert_active <= 1'b1;
    end else begin
      cs_s1_q  <= cs_n;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      sck_s1_q <= sck_i;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      boot_q   <= 1'b0;
      // serial clock mode chosen after reset and at each select fall
      if (boot_q || cs_fall)
        int_mode_q <= sck_s2_q;
      // divider keeps running across source changes; only duty moves
      if (!gen_on) begin
        ph_q      <= 2'h0;
        sck_int_q <= 1'b0;
      end else if (tick) begin
        ph_q <= ph_q + 2'h1; // [R8] [R20]
        if (ph_end)
          sck_int_q <= ~sck_int_q;
      end
      case (state_q)
        ST_CONV: begin
          cyc_q <= cyc_q + 32'h0000_0001;
          if (tick)
            per_q <= per_q + 16'h0001;
          if (conv_done) begin
            res_q   <= result_data;
            state_q <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          // source and select changes here cannot disturb anything
          if (cs_low && rise && !cs_fall) begin // [R21] [R6] [R2]
            shift_q <= {2'b00, res_q};
            falls_q <= 6'h00;
            state_q <= ST_DOUT;
          end
        end
        ST_DOUT: begin
          if (cs_rise) begin
            state_q <= ST_CONV;
          end else if (fall) begin
            shift_q <= {shift_q[30:0], 1'b1};
            falls_q <= falls_q + 6'h01;
            if (falls_q == `CCST_WORD_BITS - 1)
              state_q <= ST_CONV; // [R12] [R13] [R14] [R19]
          end
        end
        default: begin
          state_q <= ST_CONV;
        end
      endcase
      // next conversion latches the rejection choice at its start
      if (state_q != ST_CONV) begin
        cyc_q <= 32'h0000_0000;
        per_q <= 16'h0000;
        lim_q <= conv_limit(sel_high); // [R2] [R1]
      end
      if (state_q == ST_DOUT)
        serial_out <= shift_q[31]; // [R15]
      else
        serial_out <= (state_q == ST_CONV); // [R15]
      serial_out_oe  <= cs_low;
      sck_o          <= sck_int_q;
      sck_oe         <= int_mode_q & cs_low;
      int_osc_en     <= ~ext_sel; // [R3] [R5]
      convert_active <= (state_q == ST_CONV);
    end
  end
endmodule // ccst_top
`default_nettype wire

// *** common/ccst_map.vh ***
`ifndef CCST_MAP_VH
`define CCST_MAP_VH
// clock period
`define CCST_T_CLK_NS          4
// convert state durations, internal oscillator
`define CCST_T_CONV60_NS       66600000
`define CCST_T_CONV50_NS       80000000
`define CCST_T_CONVCMB_NS      72800000
// data output bound, internal serial clock, internal oscillator
`define CCST_T_DOUT_NS         1670000
`define CCST_T_DOUTCMB_NS      1830000
// external clock absence window (one period at 2560 Hz is 390625 ns)
`define CCST_T_EXT_WIN_NS      400000
// conversion clock periods per convert state, external clock
`define CCST_EXT_CONV_PERIODS  10278
// conversion clock periods per data output, and serial clock divide
`define CCST_DOUT_PERIODS      256
`define CCST_SCK_DIV           8
`define CCST_WORD_BITS         32
// derived cycle counts
`define CCST_CONV60_CYC   (`CCST_T_CONV60_NS / `CCST_T_CLK_NS)
`define CCST_CONV50_CYC   (`CCST_T_CONV50_NS / `CCST_T_CLK_NS)
`define CCST_CONVCMB_CYC  (`CCST_T_CONVCMB_NS / `CCST_T_CLK_NS)
`define CCST_TICK_CYC     (`CCST_T_DOUT_NS / (`CCST_DOUT_PERIODS * `CCST_T_CLK_NS))
`define CCST_TICKCMB_CYC  (`CCST_T_DOUTCMB_NS / (`CCST_DOUT_PERIODS * `CCST_T_CLK_NS))
`define CCST_EXT_WIN_CYC  ((`CCST_T_EXT_WIN_NS + `CCST_T_CLK_NS - 1) / `CCST_T_CLK_NS)
`endif

// *** design/ccst_clk_sel.v ***
`timescale 1ns/10ps
`default_nettype none
`include "ccst_map.vh"
module ccst_clk_sel #(
  parameter integer WIN_CYC  = `CCST_EXT_WIN_CYC,
  parameter integer TICK_CYC = `CCST_TICK_CYC
) (
  input  wire clk,
  input  wire rst,
  input  wire rejection_select_pin,
  output reg  ext_sel_q,
  output reg  conv_tick_q,
  output reg  sel_high_q
);
  reg        pin_s1_q;
  reg        pin_s2_q;
  reg        pin_s3_q;
  reg [31:0] win_q;
  reg [1:0]  edges_q;
  reg [31:0] osc_q;
  wire       pin_rise;
  wire       win_out;
  wire       osc_tick;

  assign pin_rise = pin_s2_q & ~pin_s3_q;
  assign win_out  = (win_q == WIN_CYC - 1);
  assign osc_tick = ~ext_sel_q & (osc_q == TICK_CYC - 1);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_q    <= 1'b0;
      pin_s2_q    <= 1'b0;
      pin_s3_q    <= 1'b0;
      win_q       <= 32'h0000_0000;
      edges_q     <= 2'h0;
      osc_q       <= 32'h0000_0000;
      ext_sel_q   <= 1'b0;
      conv_tick_q <= 1'b0;
      sel_high_q  <= 1'b0;
    end else begin
      pin_s1_q <= rejection_select_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      // absence window restarts on every rising edge
      if (pin_rise)
        win_q <= 32'h0000_0000;
      else if (!win_out)
        win_q <= win_q + 32'h0000_0001;
      if (pin_rise && !win_out)
        edges_q <= (edges_q == 2'h2) ? 2'h2 : edges_q + 2'h1; // [R3]
      else if (pin_rise)
        edges_q <= 2'h1;
      else if (win_out)
        edges_q <= 2'h0; // [R22] [R5]
      ext_sel_q <= (edges_q == 2'h2) & ~win_out; // [R3] [R5]
      // internal oscillator off while external clock runs
      if (ext_sel_q || osc_tick)
        osc_q <= 32'h0000_0000; // [R23]
      else
        osc_q <= osc_q + 32'h0000_0001;
      // only whole periods of either source become ticks
      conv_tick_q <= ext_sel_q ? pin_rise : osc_tick; // [R23] [R3]
      if (!ext_sel_q)
        sel_high_q <= pin_s2_q; // [R1]
    end
  end
endmodule // ccst_clk_sel
`default_nettype wire

// *** sim/ccst_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module ccst_props #(
  parameter integer WIN_CYC = 100,
  parameter integer CONV60  = 200
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rejection_select_pin,
  input wire logic cs_n,
  input wire logic sck_o,
  input wire logic sck_oe,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic int_osc_en,
  input wire logic convert_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [19:0] pst_q, chi_q, cvt_q, ost_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pst_q <= 20'h0;
      chi_q <= 20'h0;
      cvt_q <= 20'h0;
      ost_q <= 20'h0;
    end else begin
      ost_q <= $changed(int_osc_en) ? 20'h0 : ost_q + 20'h1;
      pst_q <= $changed(rejection_select_pin) ? 20'h0 : pst_q + 20'h1;
      chi_q <= cs_n ? chi_q + 20'h1 : 20'h0;
      cvt_q <= convert_active ? cvt_q + 20'h1 : 20'h0;
    end
  end
  oe_on_a: assert property ($fell(cs_n) |-> ##[1:5] serial_out_oe)
    else $error("oe late");
  oe_off_a: assert property ($rose(cs_n) |-> ##[1:5] !serial_out_oe && !sck_oe)
    else $error("release late");
  eoc_busy_a: assert property (convert_active && $past(convert_active) |-> serial_out)
    else $error("eoc low");
  // a source change mid-conversion may cut that conversion short
  conv_len_a: assert property ($fell(convert_active) && ost_q >= cvt_q |-> cvt_q >= CONV60 - 3)
    else $error("convert short");
  sleep_hold_a: assert property (chi_q > 8 && !convert_active |=> !convert_active)
    else $error("left sleep");
  osc_back_a: assert property (pst_q > WIN_CYC + 8 |-> int_osc_en)
    else $error("osc off");
  osc_off_a: assert property ($fell(int_osc_en) |-> pst_q < WIN_CYC)
    else $error("osc stop");
  sck_half_a: assert property ($rose(sck_o) |-> sck_o[*8])
    else $error("sck short");
  cover property ($fell(int_osc_en));
  cover property ($rose(sck_o));
  cover property ($fell(convert_active));
endmodule // ccst_props
bind ccst_top ccst_props #(.WIN_CYC(WIN_CYC), .CONV60(CONV60)) ccst_props_i (
  .clk, .rst, .rejection_select_pin, .cs_n, .sck_o, .sck_oe, .serial_out,
  .serial_out_oe, .int_osc_en, .convert_active);
`default_nettype wire

// *** sim/ccst_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module ccst_host (
  input  wire logic clk,
  input  wire logic sck_o,
  input  wire logic sck_oe,
  input  wire logic serial_out,
  output var  logic cs_n,
  output wire logic sck_w
);
  logic        sck_h = 1'b0;
  int          lost = 0;
  logic [31:0] last_w = 32'h0;
  logic [32:0] pair_sum = 33'h0;
  assign sck_w = sck_oe ? sck_o : sck_h;
  initial cs_n = 1'b1;
  task automatic rd(input logic ext, input int n, input int hp, output logic [31:0] w);
    int i;
    int k;
    w = 32'h0;
    sck_h = !ext; // sck level at cs fall picks mode
    repeat (2) @(posedge clk);
    #1 cs_n = 1'b0;
    repeat (8) @(posedge clk);
    for (i = 0; i < n; i++) begin
      if (ext) begin
        #1 sck_h = 1'b1; // host clocks, at most 32
        repeat (hp) @(posedge clk);
        w = {w[30:0], serial_out};
        #1 sck_h = 1'b0;
        repeat (hp) @(posedge clk);
      end else begin
        for (k = 0; k < 999 && sck_o !== 1'b0; k++) @(posedge clk);
        if (k == 999) lost++;
        for (k = 0; k < 999 && sck_o !== 1'b1; k++) @(posedge clk);
        if (k == 999) lost++;
        w = {w[30:0], serial_out};
      end
    end
    for (k = 0; k < 999 && sck_w !== 1'b0; k++) @(posedge clk);
    if (k == 999) lost++;
    #1 cs_n = 1'b1;
    // sum of the two latest whole words for averaging
    if (n == 32) begin
      pair_sum = {1'b0, last_w} + {1'b0, w};
      last_w = w;
    end
  endtask
endmodule // ccst_host
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int C60 = 200;
  localparam int C50 = 300;
  localparam int WIN = 100;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rsp = 1'b0;
  logic        ext_on = 1'b0;
  logic [29:0] res = 30'h2A5C_3E17;
  logic [31:0] w;
  int          ecnt = 0;
  int          n;
  int          err_total = 0;
  int          checked = 0;
  wire         cs_n, sck_w, sck_o, sck_oe, sout, sout_oe, osc, cva;
  always #2 clk = !clk;
  // conversion clock of 40 cycles, well above the slowest rate
  always @(posedge clk) begin
    #1;
    ecnt = (ecnt + 1) % 20;
    if (ext_on && ecnt == 0) rsp = !rsp;
  end
  ccst_top #(.CONV60(C60), .CONV50(C50), .CONVCMB(250), .EXT_CONV(20), .WIN_CYC(WIN),
    .TICK_CYC(4), .TICKCMB(4)) ccst_top_i (.clk, .rst, .rejection_select_pin(rsp), .cs_n,
    .sck_i(sck_w), .result_data(res), .sck_o, .sck_oe, .serial_out(sout),
    .serial_out_oe(sout_oe), .int_osc_en(osc), .convert_active(cva));
  ccst_host ccst_host_i (.clk, .sck_o, .sck_oe, .serial_out(sout), .cs_n, .sck_w);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wt(input bit sel, input logic v, input int lim);
    for (n = 0; (sel ? osc : cva) !== v; n++) begin
      if (n == lim) begin
        err_total++;
        test_done;
      end
      @(posedge clk) #1;
    end
  endtask
  task automatic conv(input int lim);
    wt(0, 1'b1, 20000);
    wt(0, 1'b0, lim);
  endtask
  task automatic sc_rates;
    conv(C60 + 4);
    chk(n > C60 - 4, 1);
    rsp = 1'b1;
    ccst_host_i.rd(1'b1, 32, 8, w);
    chk(w, {2'b00, res});
    chk(sout, 1'b1);
    res = 30'h1537_C0A9;
    conv(C50 + 4);
    chk(n > C50 - 16, 1);
    ccst_host_i.rd(1'b0, 32, 0, w);
    chk(w, {2'b00, res});
  endtask
  task automatic sc_ext;
    int k;
    ext_on = 1'b1;
    wt(1, 1'b0, 200);
    chk(osc, 1'b0);
    conv(20000);
    ccst_host_i.rd(1'b1, 32, 8, w);
    chk(w, {2'b00, res});
    conv(900);
    chk(n > 20 * 40 - 60, 1);
    ccst_host_i.rd(1'b0, 32, 0, w);
    chk(w, {2'b00, res});
    // stop the pin clock just after a rising edge
    for (k = 0; !(rsp && ecnt == 0); k++) begin
      if (k == 45) begin
        err_total++;
        test_done;
      end
      @(posedge clk);
    end
    #1 ext_on = 1'b0;
    wt(1, 1'b1, WIN + 20);
    chk(n > WIN - 10, 1);
  endtask
  task automatic sc_abort;
    conv(20000);
    ccst_host_i.rd(1'b1, 10, 8, w);
    chk(w, {22'h0, 2'b00, res[29:22]});
    wt(0, 1'b1, 8);
    repeat (4) @(posedge clk) #1;
    chk({cva, sout_oe}, 2'b10);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1;
    chk({sck_o, sck_oe, sout, sout_oe, osc, cva}, 6'h0B);
    rst = 1'b0;
    sc_rates;
    sc_ext;
    sc_abort;
    chk(ccst_host_i.lost, 32'h0);
    test_done;
  end
endmodule // tb
`default_nettype wire
